// [src/pcg_pkg.sv]
package pcg_pkg;
  // Register byte offsets
  localparam logic [11:0] RUN_OFS  = 12'h100;
  localparam logic [11:0] SLEEP_OFS = 12'h110;
  localparam logic [11:0] DEEP_OFS = 12'h120;
  localparam logic [11:0] CFG_OFS  = 12'h130;
  localparam logic [11:0] STAT_OFS = 12'h134;

  // Reset values
  localparam logic [31:0] RUN_RST   = 32'h0000_0000;
  localparam logic [31:0] SLEEP_RST = 32'h0000_0040;
  localparam logic [31:0] DEEP_RST  = 32'h0000_0000;
  localparam logic        CFG_RST   = 1'h0;

  // Implemented bits of a gating register
  localparam logic [31:0] GATE_MASK = 32'h0101_0348;

  // Field positions
  localparam int WATCHDOG_CLK_GATE = 3;
  localparam int HIBERNATE_CLK_GATE = 6;
  localparam int RATE_LSB = 8;
  localparam int CONVERTER_CLK_GATE = 16;
  localparam int CAN_UNIT_CLK_GATE = 24;
  localparam int CFG_AUTO_BIT = 0;
  localparam int STAT_STATE_LSB = 4;

  // Unit index on the enable and fault vectors
  localparam int U_WATCHDOG = 0;
  localparam int U_HIBERNATE = 1;
  localparam int U_ADC = 2;
  localparam int U_CAN = 3;
  localparam int N_UNITS = 4;

  // Sample rate codes
  localparam logic [1:0] RATE_1M   = 2'h3;
  localparam logic [1:0] RATE_500K = 2'h2;
  localparam logic [1:0] RATE_250K = 2'h1;
  localparam logic [1:0] RATE_125K = 2'h0;

  typedef enum logic [2:0] {
    PCG_RUN   = 3'h1,
    PCG_SLEEP = 3'h2,
    PCG_DEEP  = 3'h4
  } pcg_pstate_t;
endpackage

// [src/pcg_top.sv]
`timescale 1ns/100ps
// Contract
// R01 - Each gate bit drives one unit's clock enable; one clocks, zero stops.
// R02 - Access to an unclocked unit answers with a bus fault.
// R03 - Gate bits reset to zero unless another reset value is given.
// R04 - Software enables every unit it needs before use.
// R05 - Run, sleep and deep-sleep gating registers share one layout.
// R06 - Sleep and deep-sleep registers act only when automatic gating is set.
// R07 - Bits 9:8 pick sample rate: 3=1M, 2=500K, 1=250K, 0=125K.
// R08 - Software never asks for a rate above the converter maximum.
// R09 - Bit 6 gates the hibernation module clock.
// R10 - Bit 3 gates the watchdog; access while clear gives a bus fault.
// R11 - Bit 24 gates the CAN controller clock.
// R12 - Bit 16 gates the converter; access while unclocked gives a bus fault.
// R13 - Reserved bits read zero and ignore writes.
// R14 - Sleep gating register resets to 0x00000040.
// R15 - Surplus bit positions behave as reserved.
// R16 - Run gating register sits at offset 0x100.
// R17 - Deep-sleep gating register sits at offset 0x120, same layout.
// R18 - Enables follow run register unless auto gating and a sleep state.
// R19 - Enables change only on registered, synchronous edges, glitch free; the enable flops clear asynchronously when presetn falls.
module pcg_top #(
  parameter logic [1:0] SAMPLE_MAX = pcg_pkg::RATE_1M
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sleep_req,
  input  wire logic        deep_sleep_req,
  input  wire logic [3:0]  unit_access,
  output logic      [3:0]  unit_fault,
  output logic      [3:0]  unit_clk_en,
  output logic      [1:0]  converter_sample_rate_sel
);

  logic [31:0]         run_clk_gate_reg_q;
  logic [31:0]         sleep_clk_gate_reg_q;
  logic [31:0]         deep_sleep_clk_gate_reg_q;
  logic                auto_clk_gate_sel_q;
  pcg_pkg::pcg_pstate_t pstate_q;
  pcg_pkg::pcg_pstate_t pstate_d;
  logic [31:0]         eff_vec;
  logic [3:0]          unit_clk_en_q;
  logic [3:0]          eff_gate;
  logic [1:0]          rate_q;
  logic [1:0]          rate_d;
  logic [31:0]         prdata_q;
  logic                pslverr_q;
  logic                setup_ph;
  logic                wr_en;
  logic [31:0]         wr_val;
  logic [31:0]         rd_val;
  logic                rd_hit;

  // Gate bits pulled out of a register image
  function automatic logic [3:0] gate_vec(input logic [31:0] r);
    gate_vec = {r[pcg_pkg::CAN_UNIT_CLK_GATE], r[pcg_pkg::CONVERTER_CLK_GATE],
                r[pcg_pkg::HIBERNATE_CLK_GATE], r[pcg_pkg::WATCHDOG_CLK_GATE]};
  endfunction

  // Address compare on word boundary
  function automatic logic reg_sel(input logic [11:0] a, input logic [11:0] ofs);
    reg_sel = (a[11:2] == ofs[11:2]);
  endfunction

  // APB decode
  assign setup_ph = psel && !penable;
  assign wr_en    = psel && penable && pwrite;
  assign wr_val   = pwdata & pcg_pkg::GATE_MASK; // R13 R15

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_clk_gate_reg_q <= pcg_pkg::RUN_RST; // R03
    end else if (wr_en && reg_sel(paddr, pcg_pkg::RUN_OFS)) begin
      run_clk_gate_reg_q <= wr_val; // R16 R05
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_clk_gate_reg_q <= pcg_pkg::SLEEP_RST; // R14
    end else if (wr_en && reg_sel(paddr, pcg_pkg::SLEEP_OFS)) begin
      sleep_clk_gate_reg_q <= wr_val; // R05
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deep_sleep_clk_gate_reg_q <= pcg_pkg::DEEP_RST; // R03
    end else if (wr_en && reg_sel(paddr, pcg_pkg::DEEP_OFS)) begin
      deep_sleep_clk_gate_reg_q <= wr_val; // R17
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_clk_gate_sel_q <= pcg_pkg::CFG_RST;
    end else if (wr_en && reg_sel(paddr, pcg_pkg::CFG_OFS)) begin
      auto_clk_gate_sel_q <= pwdata[pcg_pkg::CFG_AUTO_BIT];
    end
  end

  // Read mux; unmapped words read zero and flag an error
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    if (reg_sel(paddr, pcg_pkg::RUN_OFS)) begin
      rd_val = run_clk_gate_reg_q;
    end else if (reg_sel(paddr, pcg_pkg::SLEEP_OFS)) begin
      rd_val = sleep_clk_gate_reg_q;
    end else if (reg_sel(paddr, pcg_pkg::DEEP_OFS)) begin
      rd_val = deep_sleep_clk_gate_reg_q;
    end else if (reg_sel(paddr, pcg_pkg::CFG_OFS)) begin
      rd_val[pcg_pkg::CFG_AUTO_BIT] = auto_clk_gate_sel_q;
    end else if (reg_sel(paddr, pcg_pkg::STAT_OFS)) begin
      rd_val[3:0] = unit_clk_en_q;
      rd_val[pcg_pkg::STAT_STATE_LSB +: 3] = pstate_q;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Read data and error captured in the setup cycle so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup_ph) begin
      prdata_q  <= (pwrite || !rd_hit) ? 32'h0000_0000 : rd_val;
      pslverr_q <= !rd_hit;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = pslverr_q && psel && penable;

  // Power state follows the request levels, deep sleep first
  always_comb begin
    case (1'b1)
      deep_sleep_req: pstate_d = pcg_pkg::PCG_DEEP;
      sleep_req:      pstate_d = pcg_pkg::PCG_SLEEP;
      default:        pstate_d = pcg_pkg::PCG_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pstate_q <= pcg_pkg::PCG_RUN;
    end else begin
      pstate_q <= pstate_d;
    end
  end

  // Gating vector in force
  always_comb begin
    case (pstate_q)
      pcg_pkg::PCG_SLEEP: begin
        eff_vec = auto_clk_gate_sel_q ? sleep_clk_gate_reg_q : run_clk_gate_reg_q; // R06 R18
      end
      pcg_pkg::PCG_DEEP: begin
        eff_vec = auto_clk_gate_sel_q ? deep_sleep_clk_gate_reg_q : run_clk_gate_reg_q; // R06 R18
      end
      default: begin
        eff_vec = run_clk_gate_reg_q; // R18
      end
    endcase
  end

  assign eff_gate = gate_vec(eff_vec);

  // One enable flop per unit; the downstream gating cell sees only clean edges
  genvar gi;
  generate
    for (gi = 0; gi < pcg_pkg::N_UNITS; gi++) begin : g_en
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          unit_clk_en_q[gi] <= 1'b0; // R03
        end else begin
          unit_clk_en_q[gi] <= eff_gate[gi]; // R01 R09 R10 R11 R12 R19
        end
      end
    end
  endgenerate

  assign unit_clk_en = unit_clk_en_q;

  // Rate clamped so a bad request cannot overdrive the converter
  assign rate_d = (eff_vec[pcg_pkg::RATE_LSB +: 2] > SAMPLE_MAX) ?
                  SAMPLE_MAX : eff_vec[pcg_pkg::RATE_LSB +: 2]; // R07 R08

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_q <= pcg_pkg::RATE_125K;
    end else begin
      rate_q <= rate_d; // R07
    end
  end

  assign converter_sample_rate_sel = rate_q;

  // Fault answer for a unit touched while unclocked
  assign unit_fault = unit_access & ~unit_clk_en_q; // R02 R10 R12

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  reset_value_a: assert property ( // R03
    $rose(presetn) |-> (run_clk_gate_reg_q == pcg_pkg::RUN_RST) && (unit_clk_en == 4'h0)
  ) else $error("gate state not cleared at reset");

  sleep_reset_a: assert property ( // R14
    $rose(presetn) |-> sleep_clk_gate_reg_q == pcg_pkg::SLEEP_RST
  ) else $error("sleep gating reset value wrong");

  reserved_zero_a: assert property ( // R13
    ((run_clk_gate_reg_q | sleep_clk_gate_reg_q | deep_sleep_clk_gate_reg_q)
      & ~pcg_pkg::GATE_MASK) == 32'h0000_0000
  ) else $error("reserved gating bit set");

  run_write_a: assert property ( // R16
    wr_en && paddr == pcg_pkg::RUN_OFS
    |=> run_clk_gate_reg_q == ($past(pwdata) & pcg_pkg::GATE_MASK)
  ) else $error("run gating write lost");

  deep_write_a: assert property ( // R17
    wr_en && paddr == pcg_pkg::DEEP_OFS
    |=> deep_sleep_clk_gate_reg_q == ($past(pwdata) & pcg_pkg::GATE_MASK)
  ) else $error("deep gating write lost");

  manual_gate_a: assert property ( // R06
    !auto_clk_gate_sel_q ##1 !auto_clk_gate_sel_q
    |=> unit_clk_en == gate_vec($past(run_clk_gate_reg_q, 1))
  ) else $error("sleep gating used without auto mode");

  sleep_gate_a: assert property ( // R18
    auto_clk_gate_sel_q && pstate_q == pcg_pkg::PCG_SLEEP
    |=> unit_clk_en == gate_vec($past(sleep_clk_gate_reg_q))
  ) else $error("sleep vector not applied");

  state_follow_a: assert property ( // R18
    deep_sleep_req |=> pstate_q == pcg_pkg::PCG_DEEP
  ) else $error("deep sleep state not entered");

  rate_limit_a: assert property ( // R07
    eff_vec[pcg_pkg::RATE_LSB +: 2] <= SAMPLE_MAX
    |=> converter_sample_rate_sel == $past(eff_vec[pcg_pkg::RATE_LSB +: 2])
  ) else $error("sample rate not passed through");

  watchdog_fault_a: assert property ( // R10
    unit_access[pcg_pkg::U_WATCHDOG] && !unit_clk_en[pcg_pkg::U_WATCHDOG] |-> unit_fault[pcg_pkg::U_WATCHDOG]
  ) else $error("watchdog access not faulted");

  adc_fault_a: assert property ( // R12
    unit_access[pcg_pkg::U_ADC] && unit_clk_en[pcg_pkg::U_ADC] |-> !unit_fault[pcg_pkg::U_ADC]
  ) else $error("clocked converter access faulted");

  en_settle_a: assert property ( // R19
    $stable(eff_vec) ##1 $stable(eff_vec) |-> $stable(unit_clk_en)
  ) else $error("enable moved without cause");

  deep_reset_a: assert property ( // R03
    $rose(presetn) |-> (deep_sleep_clk_gate_reg_q == pcg_pkg::DEEP_RST)
      && (converter_sample_rate_sel == pcg_pkg::RATE_125K)
  ) else $error("deep gating or rate not cleared at reset");

  sleep_write_a: assert property ( // R05
    wr_en && paddr == pcg_pkg::SLEEP_OFS
    |=> sleep_clk_gate_reg_q == ($past(pwdata) & pcg_pkg::GATE_MASK)
  ) else $error("sleep gating write lost");

  deep_gate_a: assert property ( // R06
    auto_clk_gate_sel_q && pstate_q == pcg_pkg::PCG_DEEP
    |=> unit_clk_en == gate_vec($past(deep_sleep_clk_gate_reg_q))
  ) else $error("deep sleep vector not applied");

  run_state_a: assert property ( // R18
    pstate_q == pcg_pkg::PCG_RUN
    |=> unit_clk_en == gate_vec($past(run_clk_gate_reg_q))
  ) else $error("run vector not applied");

  sleep_follow_a: assert property ( // R18
    sleep_req && !deep_sleep_req |=> pstate_q == pcg_pkg::PCG_SLEEP
  ) else $error("sleep state not entered");

  hib_gate_a: assert property ( // R09
    pstate_q == pcg_pkg::PCG_RUN
    |=> unit_clk_en[pcg_pkg::U_HIBERNATE] == $past(run_clk_gate_reg_q[pcg_pkg::HIBERNATE_CLK_GATE])
  ) else $error("hibernation enable not on its bit");

  can_gate_a: assert property ( // R11
    pstate_q == pcg_pkg::PCG_RUN
    |=> unit_clk_en[pcg_pkg::U_CAN] == $past(run_clk_gate_reg_q[pcg_pkg::CAN_UNIT_CLK_GATE])
  ) else $error("CAN enable not on its bit");

  can_fault_a: assert property ( // R02
    unit_access[pcg_pkg::U_CAN] && !unit_clk_en[pcg_pkg::U_CAN] |-> unit_fault[pcg_pkg::U_CAN]
  ) else $error("CAN access not faulted");

  rate_clamp_a: assert property ( // R07
    eff_vec[pcg_pkg::RATE_LSB +: 2] > SAMPLE_MAX
    |=> converter_sample_rate_sel == SAMPLE_MAX
  ) else $error("sample rate not clamped");

endmodule

// [verif/tb.sv]
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin \
  checks_done++; \
  if ((gt) !== (ex)) begin \
    n_mismatch++; \
    $display("[ERR] %s exp %h got %h", nm, ex, gt); \
  end \
end
module tb;
  logic        pclk           = 1'b0;
  logic        presetn        = 1'b0;
  logic        psel           = 1'b0;
  logic        penable        = 1'b0;
  logic        pwrite         = 1'b0;
  logic [11:0] paddr          = 12'h000;
  logic [31:0] pwdata         = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sleep_req      = 1'b0;
  logic        deep_sleep_req = 1'b0;
  logic [3:0]  unit_access    = 4'hF;
  logic [3:0]  unit_fault;
  logic [3:0]  unit_clk_en;
  logic [1:0]  converter_sample_rate_sel;
  int          n_mismatch     = 0;
  int          checks_done    = 0;
  int          cyc            = 0;

  pcg_top i_pcg_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req), .unit_access(unit_access),
    .unit_fault(unit_fault), .unit_clk_en(unit_clk_en), .converter_sample_rate_sel(converter_sample_rate_sel));

  always #5 pclk = ~pclk;

  // Budget well above the roughly 150 cycles the tests need
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    if (n_mismatch == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, a, d, rd, er);
    `CHK("write err", 1'b0, er)
  endtask

  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] ex);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, a, 32'h0000_0000, rd, er);
    `CHK(nm, ex, rd)
    `CHK("read err", 1'b0, er)
  endtask

  // Enable lags a register write by one edge, a request by two; three gives margin
  // Sampled 1ns after an edge, then back on an edge so later drives stay aligned
  task automatic en_chk(input logic [3:0] e);
    repeat (3) @(posedge pclk);
    #1;
    `CHK("clk_en", e, unit_clk_en)
    `CHK("fault", unit_access & ~e, unit_fault)
    @(posedge pclk);
  endtask

  task automatic t_reset;
    `CHK("ready", 1'b1, pready)
    rdchk("run", pcg_pkg::RUN_OFS, 32'h0000_0000);
    rdchk("sleep", pcg_pkg::SLEEP_OFS, 32'h0000_0040);
    rdchk("deep", pcg_pkg::DEEP_OFS, 32'h0000_0000);
    rdchk("cfg", pcg_pkg::CFG_OFS, 32'h0000_0000);
    en_chk(4'h0);
    `CHK("rate", 2'h0, converter_sample_rate_sel)
  endtask

  task automatic t_mask;
    wr(pcg_pkg::RUN_OFS, 32'hFFFF_FFFF);
    rdchk("run mask", pcg_pkg::RUN_OFS, 32'h0101_0348);
    wr(pcg_pkg::SLEEP_OFS, 32'hFFFF_FFFF);
    rdchk("sleep mask", pcg_pkg::SLEEP_OFS, 32'h0101_0348);
    wr(pcg_pkg::DEEP_OFS, 32'hFFFF_FFFF);
    rdchk("deep mask", pcg_pkg::DEEP_OFS, 32'h0101_0348);
    en_chk(4'hF);
  endtask

  task automatic t_units;
    int bits[4] = '{3, 6, 16, 24};
    for (int i = 0; i < 4; i++) begin
      wr(pcg_pkg::RUN_OFS, 32'h1 << bits[i]);
      en_chk(4'h1 << i);
    end
  endtask

  task automatic t_rate;
    for (int r = 0; r < 4; r++) begin
      wr(pcg_pkg::RUN_OFS, 32'(r) << 8);
      en_chk(4'h0);
      `CHK("rate", 2'(r), converter_sample_rate_sel)
    end
  endtask

  task automatic t_auto;
    wr(pcg_pkg::RUN_OFS, 32'h0000_0008);
    wr(pcg_pkg::SLEEP_OFS, 32'h0000_0040);
    wr(pcg_pkg::DEEP_OFS, 32'h0100_0200);
    sleep_req <= 1'b1;
    en_chk(4'h1);
    wr(pcg_pkg::CFG_OFS, 32'h0000_0001);
    en_chk(4'h2);
    deep_sleep_req <= 1'b1;
    en_chk(4'h8);
    `CHK("deep rate", 2'h2, converter_sample_rate_sel)
    rdchk("status", pcg_pkg::STAT_OFS, 32'h0000_0048);
    sleep_req      <= 1'b0;
    deep_sleep_req <= 1'b0;
    unit_access    <= 4'h5;
    en_chk(4'h1);
  endtask

  task automatic t_unmapped;
    logic [31:0] rd;
    logic        er;
    apb(1'b0, 12'h104, 32'h0000_0000, rd, er);
    `CHK("unmapped err", 1'b1, er)
    `CHK("unmapped data", 32'h0000_0000, rd)
    // Mid-run reset must leave every enable dropped, checked three edges after presetn falls
    presetn <= 1'b0;
    en_chk(4'h0);
    presetn <= 1'b1;
    rdchk("run after reset", pcg_pkg::RUN_OFS, 32'h0000_0000);
    rdchk("sleep after reset", pcg_pkg::SLEEP_OFS, 32'h0000_0040);
    rdchk("deep after reset", pcg_pkg::DEEP_OFS, 32'h0000_0000);
    rdchk("cfg after reset", pcg_pkg::CFG_OFS, 32'h0000_0000);
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_mask();
    t_units();
    t_rate();
    t_auto();
    t_unmapped();
    wrap_up();
  end
endmodule
